// ===== design/sfhps_pkg.sv
/*
   constants, opcodes, status bit layout, state encodings and the protected
   region decode shared by both ends of the serial flash link.
   assumes a 50 MHz mclk on both ends.
*/
package sfhps_pkg;

   localparam int CLK_NS = 20;

   // instruction opcodes
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_SE_ALT = 8'hd7;
   localparam logic [7:0] OP_BE = 8'hd8;
   localparam logic [7:0] OP_CE = 8'h60;
   localparam logic [7:0] OP_CE_ALT = 8'hc7;

   // status register bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_WRITE_LATCH = 1;
   localparam int ST_LVL_LO = 2;
   localparam int ST_LVL_HI = 4;
   localparam int ST_TOP_BOTTOM = 5;
   localparam int ST_RSV = 6;
   localparam int ST_LOCK = 7;
   localparam logic [7:0] ST_NV_MASK = 8'hbc;
   localparam logic [7:0] ST_NV_INIT = 8'h00;

   // array geometry
   localparam logic [23:0] ARRAY_MASK = 24'h07ffff;
   localparam logic [23:0] ARRAY_SIZE = 24'h080000;
   localparam logic [23:0] PROT_UNIT = 24'h010000;

   // framing counts
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam logic [5:0] BITS_OP = 6'h08;
   localparam logic [5:0] BITS_ADDR = 6'h18;
   localparam logic [5:0] BITS_DATA = 6'h08;

   // timing
   localparam int BUSY_TIME_NS = 2000;
   localparam logic [7:0] BUSY_CYCLES =
      8'((BUSY_TIME_NS + CLK_NS - 1) / CLK_NS);
   localparam int SCK_HALF_NS = 60;
   localparam logic [2:0] SCK_HALF_CYCLES =
      3'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [3:0] {
      PH_OP = 4'b0001,
      PH_ADDR = 4'b0010,
      PH_DATA = 4'b0100,
      PH_DONE = 4'b1000
   } sfhps_phase_e;

   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_LEAD = 5'b00010,
      H_LOW = 5'b00100,
      H_HIGH = 5'b01000,
      H_TAIL = 5'b10000
   } sfhps_hstate_e;

   // high when addr lies inside the region chosen by level and top/bottom
   function automatic logic in_protected(logic [2:0] lvl, logic topBottom,
                                         logic [23:0] addr);
      logic [23:0] a;
      logic [23:0] size;
      a = addr & ARRAY_MASK;
      size = PROT_UNIT << (lvl[1:0] - 2'h1);
      if (lvl[2])
         return 1'b1;
      if (lvl[1:0] == 2'h0)
         return 1'b0;
      if (topBottom)
         return a < size;
      return a >= (ARRAY_SIZE - size);
   endfunction

endpackage

// ===== design/sfhps_if.sv
/*
   the four-wire link plus hold and write-protect pins between host and flash.
   assumes the bench connects one host and one device; the data-out line is
   resolved here from the device's enable, with a weak-high idle level.
*/
`timescale 1ns/1ns
interface sfhps_if;
   logic csN;
   logic sck;
   logic mosi;
   logic holdN;
   logic wpN;
   logic soData;
   logic soOe;
   logic miso;

   assign miso = soOe ? soData : 1'b1;

   modport host (output csN, output sck, output mosi, output holdN,
                 output wpN, input miso);
   modport device (input csN, input sck, input mosi, input holdN,
                   input wpN, output soData, output soOe);
endinterface

// ===== design/sfhps_device.sv
/*
   flash end: serial command front end on the link clock, status register
   and busy timer on mclk.
   assumes sck is idle while sys_rst is high and while chip select is high.
*/
// Contract
// - works in clock modes zero and three
// - sample on rising, drive after falling
// - host frames all traffic with chip select
// - hold falling at clock low pauses
// - hold rising at clock low resumes
// - host moves hold only with clock low
// - paused: output off, input ignored
// - pause freezes shift and sequencer position
// - deselect during pause abandons the sequence
// - stays paused while hold is low
// - status write refused when locked down
// - lockdown is bit seven, gated by protect pin
// - bit zero is read-only busy flag
// - no program or erase without enable latch
// - enable latch cleared on listed completions
// - protection bits writable, bit six reads zero
// - locked: protection bits become read-only
// - top/bottom places region low or high
// - chip erase only with levels all zero
// - host only polls status while busy
// - level encoding selects protected address range
// - host sends write enable before writes
// - early deselect aborts the instruction
`timescale 1ns/1ns
module sfhps_device
   import sfhps_pkg::*;
(
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // link
   sfhps_if.device link,
   // array side
   output logic arrayStart,
   output logic [7:0] arrayOpcode,
   output logic [23:0] arrayAddr,
   output logic [7:0] arrayData,
   output logic [7:0] statusOut
);

   typedef struct packed {
      sfhps_phase_e phase;
      logic [2:0] bitCnt;
      logic [6:0] shifter;
      logic [1:0] addrCnt;
   } sfhps_frame_s;

   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
      logic reqTog;
      logic [7:0] stMeta;
      logic [7:0] stSync;
   } sfhps_capt_s;

   typedef struct packed {
      logic soData;
      logic soOe;
   } sfhps_out_s;

   typedef struct packed {
      logic [1:0] csSync;
      logic [1:0] togSync;
      logic [1:0] wpSync;
      logic seenTog;
      logic [7:0] status;
      logic [7:0] busyCnt;
      logic arrayStart;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
   } sfhps_core_s;

   sfhps_frame_s f, next_f;
   sfhps_capt_s c, next_c;
   sfhps_out_s o, next_o;
   sfhps_core_s m, next_m;

   ////////////////////////////////////////////////////////////////////////
   // link clock: shift in, decode instruction framing

   always_comb begin
      logic [7:0] inByte;
      logic hasAddr;
      inByte = {f.shifter, link.mosi};
      hasAddr = (inByte == OP_PROG) || (inByte == OP_SE) ||
                (inByte == OP_SE_ALT) || (inByte == OP_BE);
      next_f = f;
      next_c = c;
      next_c.stMeta = m.status;
      next_c.stSync = c.stMeta;
      // edges seen with hold low are dropped, position kept
      if (link.holdN) begin
         next_f.shifter = inByte[6:0];
         next_f.bitCnt = f.bitCnt + 3'h1;
         if (f.bitCnt == BIT_LAST) begin
            case (f.phase)
               PH_OP: begin
                  next_c.opcode = inByte;
                  next_f.addrCnt = 2'h0;
                  if (hasAddr) begin
                     next_f.phase = PH_ADDR;
                  end else if (inByte == OP_STATUS_WRITE ||
                               inByte == OP_RDSR) begin
                     next_f.phase = PH_DATA;
                  end else begin
                     next_c.reqTog = ~c.reqTog;
                     next_f.phase = PH_DONE;
                  end
               end
               PH_ADDR: begin
                  next_c.addr = {c.addr[15:0], inByte};
                  next_f.addrCnt = f.addrCnt + 2'h1;
                  if (f.addrCnt == ADDR_LAST) begin
                     if (c.opcode == OP_PROG) begin
                        next_f.phase = PH_DATA;
                     end else begin
                        next_c.reqTog = ~c.reqTog;
                        next_f.phase = PH_DONE;
                     end
                  end
               end
               PH_DATA: begin
                  if (c.opcode != OP_RDSR) begin
                     next_c.data = inByte;
                     next_c.reqTog = ~c.reqTog;
                     next_f.phase = PH_DONE;
                  end
               end
               PH_DONE: begin
                  next_f.phase = PH_DONE;
               end
               default: begin
                  next_f.phase = PH_DONE;
               end
            endcase
         end
      end
   end

   // deselect clears the frame, so a partial byte never issues
   always_ff @(posedge link.sck or posedge link.csN) begin
      if (link.csN) begin
         f <= '{phase: PH_OP, bitCnt: 3'h0, shifter: 7'h00,
                addrCnt: 2'h0};
      end else begin
         f <= next_f;
      end
   end

   always_ff @(posedge link.sck or posedge sys_rst) begin
      if (sys_rst) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   // status streams out repeatedly, msb first, after each falling edge
   always_comb begin
      next_o.soData = c.stSync[~f.bitCnt];
      next_o.soOe = (f.phase == PH_DATA) && (c.opcode == OP_RDSR) &&
                    link.holdN;
   end

   always_ff @(negedge link.sck or posedge link.csN) begin
      if (link.csN) begin
         o <= '0;
      end else begin
         o <= next_o;
      end
   end

   assign link.soData = o.soData;
   // hold releases the line at once, with no clock edge to wait for
   assign link.soOe = o.soOe && link.holdN;

   ////////////////////////////////////////////////////////////////////////
   // mclk: execute a completed instruction once deselected

   always_comb begin
      logic exec;
      logic locked;
      logic [2:0] lvl;
      logic topBottom;
      logic blocked;
      next_m = m;
      next_m.arrayStart = 1'b0;
      next_m.csSync = {m.csSync[0], link.csN};
      next_m.togSync = {m.togSync[0], c.reqTog};
      next_m.wpSync = {m.wpSync[0], link.wpN};
      exec = (m.togSync[1] != m.seenTog) && m.csSync[1];
      locked = !m.wpSync[1] && m.status[ST_LOCK];
      lvl = m.status[ST_LVL_HI:ST_LVL_LO];
      topBottom = m.status[ST_TOP_BOTTOM];
      blocked = in_protected(lvl, topBottom, c.addr);
      if (exec) begin
         next_m.seenTog = m.togSync[1];
      end
      if (m.status[ST_BUSY]) begin
         // instructions other than status reads are dropped while busy
         if (m.busyCnt == 8'h00) begin
            next_m.status[ST_BUSY] = 1'b0;
            next_m.status[ST_WRITE_LATCH] = 1'b0;
         end else begin
            next_m.busyCnt = m.busyCnt - 8'h01;
         end
      end else if (exec) begin
         case (c.opcode)
            OP_WRITE_ENABLE: begin
               next_m.status[ST_WRITE_LATCH] = 1'b1;
            end
            OP_WRITE_DISABLE: begin
               next_m.status[ST_WRITE_LATCH] = 1'b0;
            end
            OP_STATUS_WRITE: begin
               if (!locked) begin
                  next_m.status = (c.data & ST_NV_MASK) |
                                  (m.status & ~ST_NV_MASK);
                  next_m.status[ST_WRITE_LATCH] = 1'b0;
               end
            end
            OP_PROG, OP_SE, OP_SE_ALT, OP_BE, OP_CE, OP_CE_ALT: begin
               if (c.opcode == OP_CE || c.opcode == OP_CE_ALT) begin
                  blocked = (lvl != 3'h0);
               end
               // refused writes leave the latch set
               if (m.status[ST_WRITE_LATCH] && !blocked) begin
                  next_m.status[ST_BUSY] = 1'b1;
                  next_m.busyCnt = BUSY_CYCLES - 8'h01;
                  next_m.arrayStart = 1'b1;
                  next_m.opcode = c.opcode;
                  next_m.addr = c.addr & ARRAY_MASK;
                  next_m.data = c.data;
               end
            end
            default: begin
               next_m.status = m.status;
            end
         endcase
      end
      next_m.status[ST_RSV] = 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         m <= '0;
         m.csSync <= 2'h3;
         m.wpSync <= 2'h3;
         m.status <= ST_NV_INIT;
      end else begin
         m <= next_m;
      end
   end

   assign arrayStart = m.arrayStart;
   assign arrayOpcode = m.opcode;
   assign arrayAddr = m.addr;
   assign arrayData = m.data;
   assign statusOut = m.status;

endmodule

// ===== design/sfhps_host.sv
/*
   host end: makes the serial clock from mclk by a divider, frames one
   instruction per request, pauses with hold on request.
   assumes requests come from mclk logic; miso is the resolved link wire.
*/
`timescale 1ns/1ns
module sfhps_host
   import sfhps_pkg::*;
(
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // link
   sfhps_if.host link,
   // request
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdOpcode,
   input wire logic [23:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic cmdHasAddr,
   input wire logic cmdHasData,
   input wire logic cmdIdleHigh,
   // pin levels
   input wire logic pauseReq,
   input wire logic wpLevel,
   // answer
   output logic rspValid,
   output logic [7:0] rspData
);

   typedef struct packed {
      sfhps_hstate_e state;
      logic [2:0] cnt;
      logic [5:0] bitsLeft;
      logic [39:0] shiftOut;
      logic idleHigh;
      logic [1:0] misoSync;
      logic [7:0] rxShift;
      logic csN;
      logic sck;
      logic mosi;
      logic holdN;
      logic wpN;
      logic cmdReady;
      logic rspValid;
      logic [7:0] rspData;
   } sfhps_host_s;

   sfhps_host_s h, next_h;

   ////////////////////////////////////////////////////////////////////////
   // bit sequencer: each bit is a low half then a high half

   always_comb begin
      next_h = h;
      next_h.rspValid = 1'b0;
      next_h.wpN = wpLevel;
      next_h.misoSync = {h.misoSync[0], link.miso};
      if (h.cnt != 3'h0) begin
         next_h.cnt = h.cnt - 3'h1;
      end
      case (h.state)
         H_IDLE: begin
            next_h.sck = h.idleHigh;
            if (cmdValid) begin
               next_h.idleHigh = cmdIdleHigh;
               next_h.sck = cmdIdleHigh;
               next_h.shiftOut = {cmdOpcode, cmdAddr, cmdData};
               if (!cmdHasAddr) begin
                  next_h.shiftOut[31:8] = {cmdData, 16'h0000};
               end
               next_h.bitsLeft = BITS_OP + (cmdHasAddr ? BITS_ADDR : 6'h00)
                                 + (cmdHasData ? BITS_DATA : 6'h00);
               next_h.cmdReady = 1'b0;
               next_h.cnt = SCK_HALF_CYCLES - 3'h1;
               next_h.state = H_LEAD;
            end
         end
         H_LEAD: begin
            // select only after sck has settled at its idle level
            next_h.csN = 1'b0;
            next_h.mosi = h.shiftOut[39];
            if (h.cnt == 3'h0) begin
               next_h.sck = 1'b0;
               next_h.cnt = SCK_HALF_CYCLES - 3'h1;
               next_h.state = H_LOW;
            end
         end
         H_LOW: begin
            // hold moves only here, with the clock low and selected
            if (h.cnt == 3'h0) begin
               if (pauseReq) begin
                  next_h.holdN = 1'b0;
               end else if (!h.holdN) begin
                  next_h.holdN = 1'b1;
                  next_h.cnt = SCK_HALF_CYCLES - 3'h1;
               end else begin
                  next_h.sck = 1'b1;
                  next_h.rxShift = {h.rxShift[6:0], h.misoSync[1]};
                  next_h.bitsLeft = h.bitsLeft - 6'h01;
                  next_h.cnt = SCK_HALF_CYCLES - 3'h1;
                  next_h.state = H_HIGH;
               end
            end
         end
         H_HIGH: begin
            if (h.cnt == 3'h0) begin
               next_h.cnt = SCK_HALF_CYCLES - 3'h1;
               if (h.bitsLeft == 6'h00) begin
                  next_h.sck = h.idleHigh;
                  next_h.state = H_TAIL;
               end else begin
                  next_h.sck = 1'b0;
                  next_h.shiftOut = {h.shiftOut[38:0], 1'b0};
                  next_h.mosi = h.shiftOut[38];
                  next_h.state = H_LOW;
               end
            end
         end
         H_TAIL: begin
            if (h.cnt == 3'h0) begin
               next_h.csN = 1'b1;
               next_h.cmdReady = 1'b1;
               next_h.rspValid = 1'b1;
               next_h.rspData = h.rxShift;
               next_h.state = H_IDLE;
            end
         end
         default: begin
            next_h.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         h <= '0;
         h.state <= H_IDLE;
         h.csN <= 1'b1;
         h.holdN <= 1'b1;
         h.wpN <= 1'b1;
         h.cmdReady <= 1'b1;
      end else begin
         h <= next_h;
      end
   end

   assign link.csN = h.csN;
   assign link.sck = h.sck;
   assign link.mosi = h.mosi;
   assign link.holdN = h.holdN;
   assign link.wpN = h.wpN;
   assign cmdReady = h.cmdReady;
   assign rspValid = h.rspValid;
   assign rspData = h.rspData;

endmodule

// ===== bench/sfhps_properties.sv
/*
   timing checks on the host-to-flash link signals.
   assumes plain inputs tied to the link interface, sampled on mclk.
*/
`timescale 1ns/1ns
module sfhps_properties (
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // link
   input wire logic csN,
   input wire logic sck,
   input wire logic mosi,
   input wire logic holdN,
   input wire logic wpN,
   input wire logic soData,
   input wire logic soOe,
   input wire logic miso
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////////
   a_out_off_deselect: assert property (csN |-> !soOe)
      else $error("data out driven while deselected");
   a_out_falling_edge: assert property (
      soOe && $past(soOe) && $changed(soData) |-> !sck)
      else $error("data out changed while clock high");
   a_out_stable_high: assert property (
      sck && $past(sck) && soOe |-> $stable(soData))
      else $error("data out moved in high half");
   a_input_stable_high: assert property (
      $rose(sck) && !csN |=> $stable(mosi) [*2])
      else $error("data in moved in high half");
   a_hold_clock_low: assert property (
      $changed(holdN) |-> !sck && !$past(sck))
      else $error("hold moved with clock high");
   a_hold_selected: assert property (!holdN |-> !csN)
      else $error("hold asserted while deselected");
   a_pause_clock_stops: assert property (
      !holdN && !$past(holdN) |-> $stable(sck))
      else $error("clock moved during pause");
   a_pause_out_off: assert property (
      !holdN && !$past(holdN, 2) |-> !soOe && miso)
      else $error("data out driven during pause");
   c_pause_seen: cover property ($fell(holdN));
endmodule

// ===== bench/serial_flash_hold_protect_status_bench.sv
/*
   self-checking bench: host and flash ends joined by the link interface.
   assumes both ends run from one 50 MHz mclk; the host makes the link clock.
*/
`timescale 1ns/1ns
module serial_flash_hold_protect_status_bench;
   import sfhps_pkg::*;
   logic mclk = 0;
   logic sys_rst = 0;
   logic cmdValid = 0;
   logic cmdReady;
   logic [7:0] cmdOpcode = 8'h00;
   logic [23:0] cmdAddr = 24'h000000;
   logic [7:0] cmdData = 8'h00;
   logic cmdHasAddr = 0;
   logic cmdHasData = 0;
   logic idleHigh = 0;
   logic pauseReq = 0;
   logic wpLevel = 1;
   logic rspValid;
   logic [7:0] rspData;
   logic arrayStart;
   logic [7:0] arrayOpcode;
   logic [23:0] arrayAddr;
   logic [7:0] arrayData;
   logic [7:0] statusOut;
   int nStart = 0;
   int n_fail = 0;
   int n_compared = 0;

   sfhps_if link ();
   sfhps_host sfhps_host_i (.mclk(mclk), .sys_rst(sys_rst), .link(link),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdHasAddr(cmdHasAddr),
      .cmdHasData(cmdHasData), .cmdIdleHigh(idleHigh),
      .pauseReq(pauseReq), .wpLevel(wpLevel), .rspValid(rspValid),
      .rspData(rspData));
   sfhps_device sfhps_device_i (.mclk(mclk), .sys_rst(sys_rst),
      .link(link), .arrayStart(arrayStart), .arrayOpcode(arrayOpcode),
      .arrayAddr(arrayAddr), .arrayData(arrayData), .statusOut(statusOut));
   sfhps_properties sfhps_properties_i (.mclk(mclk), .sys_rst(sys_rst),
      .csN(link.csN), .sck(link.sck), .mosi(link.mosi),
      .holdN(link.holdN), .wpN(link.wpN), .soData(link.soData),
      .soOe(link.soOe), .miso(link.miso));

   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      if (arrayStart === 1'b1)
         nStart <= nStart + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [23:0] got, input logic [23:0] exp,
                        input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic settle();
      repeat (8) @(posedge mclk);
   endtask

   // one framed instruction; returns after the answer pulse
   task automatic send(input logic [7:0] op, input logic [23:0] ad,
                       input logic [7:0] dt, input logic ha,
                       input logic hd);
      int n;
      cmdValid <= 1'b1;
      cmdOpcode <= op;
      cmdAddr <= ad;
      cmdData <= dt;
      cmdHasAddr <= ha;
      cmdHasData <= hd;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmdReady !== 1'b1 && n < 50);
      cmdValid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rspValid !== 1'b1 && n < 3000);
      if (n >= 3000)
         check(24'h0, 24'h1, "answer timeout");
   endtask

   task automatic cmd(input logic [7:0] op);
      send(op, 24'h0, 8'h00, 1'b0, 1'b0);
      settle();
   endtask

   // every status write is preceded by a write enable
   task automatic wr_status(input logic [7:0] v);
      cmd(OP_WRITE_ENABLE);
      send(OP_STATUS_WRITE, 24'h0, v, 1'b0, 1'b1);
      settle();
   endtask

   task automatic rdsr(input logic [7:0] exp);
      send(OP_RDSR, 24'h0, 8'h00, 1'b0, 1'b1);
      check(24'(rspData), 24'(exp), "status read");
   endtask

   // set protection, enable writes, try one program or erase
   task automatic prot(input logic [7:0] st, input logic [7:0] op,
                       input logic [23:0] ad, input logic ok);
      int s0;
      int n;
      wr_status(st);
      cmd(OP_WRITE_ENABLE);
      s0 = nStart;
      send(op, ad, 8'h5a, op != OP_CE && op != OP_CE_ALT, op == OP_PROG);
      settle();
      check(24'(nStart - s0), 24'(ok), "start count");
      if (ok) begin
         check(24'(statusOut[0]), 24'h1, "busy set");
         check(24'(arrayOpcode), 24'(op), "opcode");
         n = 0;
         // nothing is sent while busy
         while (statusOut[0] !== 1'b0 && n < 300) begin
            @(posedge mclk);
            n++;
         end
         check(24'(statusOut), 24'(st), "after op");
      end else begin
         check(24'(statusOut), 24'(st | 8'h02), "refused");
         cmd(OP_WRITE_DISABLE);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge mclk);
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      int s0;
      // a real rising edge, so the link-side flops of the flash reset too
      sys_rst <= 1'b1;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      check(24'(statusOut), 24'h0, "reset status");
      rdsr(8'h00);
      s0 = nStart;
      send(OP_PROG, 24'h000100, 8'h11, 1'b1, 1'b1);
      settle();
      check(24'(nStart - s0), 24'h0, "no latch");
      $display("test reset done");

      idleHigh <= 1'b1;
      cmd(OP_WRITE_ENABLE);
      rdsr(8'h02);
      cmd(OP_WRITE_DISABLE);
      rdsr(8'h00);
      idleHigh <= 1'b0;
      wr_status(8'hff);
      check(24'(statusOut), 24'hbc, "write all");
      wr_status(8'h00);
      $display("test modes done");

      wpLevel <= 1'b0;
      wr_status(8'h80);
      check(24'(statusOut), 24'h80, "lock set");
      wr_status(8'h1c);
      check(24'(statusOut), 24'h82, "locked");
      wpLevel <= 1'b1;
      settle();
      wr_status(8'h00);
      check(24'(statusOut), 24'h00, "unlocked");
      $display("test lock done");

      prot(8'h00, OP_CE, 24'h0, 1'b1);
      prot(8'h04, OP_CE_ALT, 24'h0, 1'b0);
      prot(8'h04, OP_SE, 24'h070000, 1'b0);
      prot(8'h04, OP_SE_ALT, 24'h06ffff, 1'b1);
      prot(8'h24, OP_BE, 24'h00ffff, 1'b0);
      prot(8'h24, OP_PROG, 24'h010000, 1'b1);
      prot(8'h08, OP_PROG, 24'h060000, 1'b0);
      prot(8'h28, OP_SE, 24'h020000, 1'b1);
      prot(8'h0c, OP_BE, 24'h03ffff, 1'b1);
      prot(8'h2c, OP_SE, 24'h03ffff, 1'b0);
      prot(8'h10, OP_SE, 24'h000000, 1'b0);
      $display("test protection done");

      wr_status(8'h2c);
      fork
         rdsr(8'h2c);
         begin
            repeat (30) @(posedge mclk);
            pauseReq <= 1'b1;
            repeat (40) @(posedge mclk);
            pauseReq <= 1'b0;
         end
      join
      wr_status(8'h00);
      $display("test pause done");
      end_of_test();
   end
endmodule
